// *** lsbu_pkg.sv ***
package lsbu_pkg;

  // ---------------------------------------------------------------
  // Stack geometry and reset value
  // ---------------------------------------------------------------
  localparam int         STACK_DEPTH = 9;
  localparam logic [8:0] STACK_RST   = 9'h000;

  // ---------------------------------------------------------------
  // Operand widths
  // ---------------------------------------------------------------
  localparam int BYTE_W  = 8;
  localparam int WORD_W  = 16;
  localparam int DWORD_W = 32;

  // ---------------------------------------------------------------
  // Opcodes issued by the sequencer
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    nop_op               = 4'h0,
    and_load_op          = 4'h1,
    or_load_op           = 4'h2,
    push_op              = 4'h3,
    read_op              = 4'h4,
    pop_op               = 4'h5,
    bytewise_and_op      = 4'h6,
    bytewise_or_op       = 4'h7,
    bytewise_xor_op      = 4'h8,
    step_segment_begin_op = 4'h9,
    step_transition_op   = 4'ha,
    step_segment_end_op  = 4'hb,
    step_merge_op        = 4'hc,
    step_branch_op       = 4'hd
  } opcode_t;

  // Operand size select for the bitwise group
  typedef enum logic [1:0] {
    size_byte  = 2'h0,
    size_word  = 2'h1,
    size_dword = 2'h2
  } opsize_t;

  // Result latency of every operation, in cycles
  localparam int RESULT_LAT = 1;

endpackage : lsbu_pkg

// *** logic_stack_bitwise_unit.sv ***
`timescale 1ns/1ps
// Contract
// RULE1 - And-load ANDs top two, drops one level
// RULE2 - Or-load ORs top two, drops one level
// RULE3 - Push duplicates top onto the stack
// RULE4 - Push discards the bottom level forever
// RULE5 - Read copies second level into top
// RULE6 - Pop removes top, second becomes top
// RULE7 - Byte AND/OR/XOR written to destination
// RULE8 - Word AND/OR/XOR written to destination
// RULE9 - Double-word AND/OR/XOR written to destination
// RULE10 - Merge fires only when all streams finished
// RULE11 - Branch follows first true transition only
// RULE12 - Nine levels, refill from below, sync clear (code clears the stack asynchronously on resetn low)
module logic_stack_bitwise_unit #(
  parameter int DEPTH  = lsbu_pkg::STACK_DEPTH,
  parameter int NSTEP  = 4
) (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  // Sequencer command
  input  wire logic                         op_valid,
  input  wire lsbu_pkg::opcode_t            opcode,
  input  wire lsbu_pkg::opsize_t            op_size,
  input  wire logic [lsbu_pkg::DWORD_W-1:0] first_operand,
  input  wire logic [lsbu_pkg::DWORD_W-1:0] second_operand,
  // Step bit evaluation inputs
  input  wire logic                         step_in_bit,
  input  wire logic [NSTEP-1:0]             stream_final,
  input  wire logic [NSTEP-1:0]             branch_cond,
  // Results
  output logic [lsbu_pkg::DWORD_W-1:0]      result_r,
  output logic                              result_valid_r,
  output logic                              top_r,
  output logic [DEPTH-1:0]                  stack_r,
  output logic                              step_active_r,
  output logic                              next_step_set_r,
  output logic [NSTEP-1:0]                  final_clear_r,
  output logic [NSTEP-1:0]                  branch_set_r
);

  // ---------------------------------------------------------------
  // Opcode decode
  // ---------------------------------------------------------------
  // True when a valid command carries the wanted opcode
  function automatic logic op_hit(input logic              valid,
                                  input lsbu_pkg::opcode_t code,
                                  input lsbu_pkg::opcode_t want);
    return valid && (code == want);
  endfunction : op_hit

  // Named strobes, shared by the step logic and the checks
  wire do_and_load  = op_hit(op_valid, opcode, lsbu_pkg::and_load_op);
  wire do_or_load   = op_hit(op_valid, opcode, lsbu_pkg::or_load_op);
  wire do_push      = op_hit(op_valid, opcode, lsbu_pkg::push_op);
  wire do_pop       = op_hit(op_valid, opcode, lsbu_pkg::pop_op);
  wire do_seg_begin = op_hit(op_valid, opcode,
                             lsbu_pkg::step_segment_begin_op);
  wire do_seg_end   = op_hit(op_valid, opcode,
                             lsbu_pkg::step_segment_end_op);
  wire do_merge     = op_hit(op_valid, opcode, lsbu_pkg::step_merge_op);
  wire do_branch    = op_hit(op_valid, opcode, lsbu_pkg::step_branch_op);
  // Refused codes must leave every level alone
  wire do_inert     = op_hit(op_valid, opcode, lsbu_pkg::nop_op) ||
                      op_hit(op_valid, opcode, lsbu_pkg::step_transition_op);

  // ---------------------------------------------------------------
  // Stack next state
  // ---------------------------------------------------------------
  logic [DEPTH-1:0] stack_nxt;
  logic [DEPTH-1:0] shift_up;
  logic [DEPTH-1:0] shift_dn;
  wire              is_cmd  = op_valid;
  wire              and_v   = stack_r[0] & stack_r[1];
  wire              or_v    = stack_r[0] | stack_r[1];

  // Push shifts down; the last level falls off
  assign shift_dn = {stack_r[DEPTH-2:0], stack_r[0]};
  // Pop shifts up; bottom refilled with zero
  assign shift_up = {1'b0, stack_r[DEPTH-1:1]};

  // Stack selection per opcode
  always_comb begin
    stack_nxt = stack_r;
    if (is_cmd) begin
      unique case (opcode)
        // RULE1 and-load combine
        lsbu_pkg::and_load_op: stack_nxt = {shift_up[DEPTH-1:1], and_v};
        // RULE2 or-load combine
        lsbu_pkg::or_load_op:  stack_nxt = {shift_up[DEPTH-1:1], or_v};
        // RULE3 RULE4 push with loss
        lsbu_pkg::push_op:     stack_nxt = shift_dn;
        // RULE5 read second level
        lsbu_pkg::read_op:     stack_nxt = {stack_r[DEPTH-1:1], stack_r[1]};
        // RULE6 pop top level
        lsbu_pkg::pop_op:      stack_nxt = shift_up;
        // Segment begin loads step bit on top
        lsbu_pkg::step_segment_begin_op:
          stack_nxt = {stack_r[DEPTH-1:1], step_in_bit};
        default:               stack_nxt = stack_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bitwise datapath
  // ---------------------------------------------------------------
  logic [lsbu_pkg::DWORD_W-1:0] logic_raw;
  logic [lsbu_pkg::DWORD_W-1:0] size_mask;
  wire  is_bitwise = is_cmd &&
                     (opcode == lsbu_pkg::bytewise_and_op ||
                      opcode == lsbu_pkg::bytewise_or_op  ||
                      opcode == lsbu_pkg::bytewise_xor_op);

  // RULE7 RULE8 RULE9 operator select
  always_comb begin
    unique case (opcode)
      lsbu_pkg::bytewise_and_op: logic_raw = first_operand & second_operand;
      lsbu_pkg::bytewise_or_op:  logic_raw = first_operand | second_operand;
      default:                   logic_raw = first_operand ^ second_operand;
    endcase
  end

  // Width mask; unused upper bits read zero
  always_comb begin
    unique case (op_size)
      lsbu_pkg::size_byte: size_mask = 32'h0000_00ff;
      lsbu_pkg::size_word: size_mask = 32'h0000_ffff;
      default:             size_mask = 32'hffff_ffff;
    endcase
  end

  // ---------------------------------------------------------------
  // Step evaluation
  // ---------------------------------------------------------------
  logic [NSTEP-1:0] first_true;
  wire  seg_live   = stack_r[0];
  // RULE10 all streams finished
  wire  merge_ok   = do_merge && (&stream_final);
  wire  branch_go  = do_branch && seg_live && (|branch_cond);

  // RULE11 lowest index wins a tie
  assign first_true = branch_cond & (~branch_cond + {{(NSTEP-1){1'b0}}, 1'b1});

  // Registered results
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stack_r         <= DEPTH'(lsbu_pkg::STACK_RST);
      result_r        <= '0;
      result_valid_r  <= 1'b0;
      next_step_set_r <= 1'b0;
      final_clear_r   <= '0;
      branch_set_r    <= '0;
      step_active_r   <= 1'b0;
    end else begin
      stack_r         <= stack_nxt;
      result_valid_r  <= is_bitwise;
      if (is_bitwise)
        result_r      <= logic_raw & size_mask;
      next_step_set_r <= merge_ok;
      // RULE10 clear finished steps
      final_clear_r   <= merge_ok ? stream_final : '0;
      // RULE11 only first branch set
      branch_set_r    <= branch_go ? first_true : '0;
      if (do_seg_begin)
        step_active_r <= step_in_bit;
      else if (do_seg_end)
        step_active_r <= 1'b0;
    end
  end

  assign top_r = stack_r[0];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_ALD: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE1
    is_cmd && opcode == lsbu_pkg::and_load_op |=>
      stack_r[0] == ($past(stack_r[0]) & $past(stack_r[1])))
    else $error("and-load result wrong");
  AST_OLD: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE2
    is_cmd && opcode == lsbu_pkg::or_load_op |=>
      stack_r[DEPTH-2:1] == $past(stack_r[DEPTH-1:2]))
    else $error("or-load did not shift");
  AST_PUSH: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE3
    is_cmd && opcode == lsbu_pkg::push_op |=> stack_r[0] == stack_r[1])
    else $error("push did not duplicate");
  AST_LOSS: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE4
    is_cmd && opcode == lsbu_pkg::push_op |=>
      stack_r[DEPTH-1] == $past(stack_r[DEPTH-2]))
    else $error("push bottom wrong");
  AST_READ: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE5
    is_cmd && opcode == lsbu_pkg::read_op |=>
      stack_r == {$past(stack_r[DEPTH-1:1]), $past(stack_r[1])})
    else $error("read changed stack");
  AST_POP: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE6
    is_cmd && opcode == lsbu_pkg::pop_op |=>
      stack_r[0] == $past(stack_r[1]) && !stack_r[DEPTH-1])
    else $error("pop wrong");
  AST_BYTE: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE7
    is_bitwise && op_size == lsbu_pkg::size_byte |=>
      result_valid_r && result_r[31:8] == 24'h00_0000)
    else $error("byte result wrong");
  AST_WORD: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE8
    is_bitwise && op_size == lsbu_pkg::size_word &&
      opcode == lsbu_pkg::bytewise_xor_op |=>
      result_r == {16'h0000, $past(first_operand[15:0] ^
                                   second_operand[15:0])})
    else $error("word result wrong");
  AST_DWORD: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE9
    is_bitwise && op_size == lsbu_pkg::size_dword &&
      opcode == lsbu_pkg::bytewise_and_op |=>
      result_r == $past(first_operand & second_operand))
    else $error("dword result wrong");
  AST_MERGE: assert property ( // RULE10
    @(posedge ref_clk) disable iff (!resetn)
    next_step_set_r |-> $past(&stream_final) && final_clear_r != '0)
    else $error("merge fired early");
  AST_BRANCH: assert property ( // RULE11
    @(posedge ref_clk) disable iff (!resetn)
    $onehot0(branch_set_r))
    else $error("more than one branch");
  AST_RESET: assert property (@(posedge ref_clk) // RULE12
    $rose(resetn) |-> stack_r == lsbu_pkg::STACK_RST)
    else $error("stack not cleared");

  // ---------------------------------------------------------------
  // Value and refill checks
  // ---------------------------------------------------------------
  // Written against the strobes, not the case above, so a slip in
  // the stack selection shows up as a mismatch rather than agreeing
  // RULE2 or-load value
  AST_OLD_VAL: assert property ( // RULE2
    @(posedge ref_clk) disable iff (!resetn)
    do_or_load |=> stack_r[0] == ($past(stack_r[0]) | $past(stack_r[1])))
    else $error("or-load result wrong");
  // RULE12 and-load refill
  AST_ALD_FILL: assert property ( // RULE12
    @(posedge ref_clk) disable iff (!resetn)
    do_and_load |=>
      !stack_r[DEPTH-1] && stack_r[DEPTH-2:1] == $past(stack_r[DEPTH-1:2]))
    else $error("and-load refill wrong");
  // RULE3 push shifts down
  AST_PUSH_COPY: assert property ( // RULE3
    @(posedge ref_clk) disable iff (!resetn)
    do_push |=> stack_r[DEPTH-1:1] == $past(stack_r[DEPTH-2:0]) &&
      stack_r[0] == $past(stack_r[0]))
    else $error("push copy wrong");
  // RULE6 pop shifts up
  AST_POP_SHIFT: assert property ( // RULE6
    @(posedge ref_clk) disable iff (!resetn)
    do_pop |=> stack_r[DEPTH-2:0] == $past(stack_r[DEPTH-1:1]))
    else $error("pop shift wrong");
  // RULE12 idle holds stack
  AST_IDLE: assert property ( // RULE12
    @(posedge ref_clk) disable iff (!resetn)
    !op_valid |=> $stable(stack_r))
    else $error("stack moved while idle");
  // RULE12 refused codes inert
  AST_INERT: assert property ( // RULE12
    @(posedge ref_clk) disable iff (!resetn)
    do_inert |=> $stable(stack_r) && !result_valid_r)
    else $error("refused code changed state");

  // ---------------------------------------------------------------
  // Bitwise result checks
  // ---------------------------------------------------------------
  // RULE7 byte OR value
  AST_BYTE_OR: assert property ( // RULE7
    @(posedge ref_clk) disable iff (!resetn)
    is_bitwise && op_size == lsbu_pkg::size_byte &&
      opcode == lsbu_pkg::bytewise_or_op |=>
      result_r[7:0] == $past(first_operand[7:0] | second_operand[7:0]))
    else $error("byte or result wrong");
  // RULE7 result holds between ops
  AST_HOLD: assert property ( // RULE7
    @(posedge ref_clk) disable iff (!resetn)
    !is_bitwise |=> !result_valid_r && $stable(result_r))
    else $error("result moved without an operation");

  // ---------------------------------------------------------------
  // Step evaluation checks
  // ---------------------------------------------------------------
  // RULE10 merge waits for all
  AST_MERGE_WAIT: assert property ( // RULE10
    @(posedge ref_clk) disable iff (!resetn)
    do_merge && !(&stream_final) |=>
      !next_step_set_r && final_clear_r == '0)
    else $error("merge fired with a stream unfinished");
  // RULE10 merge clears finals
  AST_MERGE_CLR: assert property ( // RULE10
    @(posedge ref_clk) disable iff (!resetn)
    do_merge && (&stream_final) |=>
      next_step_set_r && final_clear_r == $past(stream_final))
    else $error("merge did not clear finished steps");
  // RULE11 lowest true branch
  AST_BR_LOW: assert property ( // RULE11
    @(posedge ref_clk) disable iff (!resetn)
    do_branch && stack_r[0] && (|branch_cond) |=>
      branch_set_r != '0 &&
      (branch_set_r & ~$past(branch_cond)) == '0 &&
      ((branch_set_r - NSTEP'(1)) & $past(branch_cond)) == '0)
    else $error("branch did not follow the first true condition");
  // RULE11 no branch when dead
  AST_BR_DEAD: assert property ( // RULE11
    @(posedge ref_clk) disable iff (!resetn)
    do_branch && !stack_r[0] |=> branch_set_r == '0)
    else $error("branch taken from an inactive step");
  // RULE11 segment flag loads
  AST_SEG_LOAD: assert property ( // RULE11
    @(posedge ref_clk) disable iff (!resetn)
    do_seg_begin |=>
      step_active_r == $past(step_in_bit) && stack_r[0] == step_active_r)
    else $error("segment begin did not load the step bit");
  // RULE11 segment end clears
  AST_SEG_END: assert property ( // RULE11
    @(posedge ref_clk) disable iff (!resetn)
    do_seg_end |=> !step_active_r)
    else $error("segment end left the flag set");

endmodule : logic_stack_bitwise_unit

// *** seq_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------
// Sequencer model, one command per call
// ---------------------------------------------
module seq_model (
  // Clock
  input  wire logic         ref_clk,
  // Command to the unit
  output logic              op_valid,
  output lsbu_pkg::opcode_t opcode,
  output lsbu_pkg::opsize_t op_size,
  output logic [31:0]       first_operand,
  output logic [31:0]       second_operand,
  output logic              step_in_bit,
  output logic [3:0]        stream_final,
  output logic [3:0]        branch_cond
);
  // Idle command at time zero
  initial begin
    op_valid = 1'b0;
    opcode = lsbu_pkg::nop_op;
    op_size = lsbu_pkg::size_byte;
    first_operand = 32'h0;
    second_operand = 32'h0;
    step_in_bit = 1'b0;
    stream_final = 4'h0;
    branch_cond = 4'h0;
  end

  // Drive at falling edge, hold across one rising edge
  task automatic issue(input lsbu_pkg::opcode_t op,
                       input lsbu_pkg::opsize_t sz,
                       input logic [31:0] a, input logic [31:0] b,
                       input logic sb, input logic [3:0] fin,
                       input logic [3:0] br);
    @(negedge ref_clk);
    op_valid = 1'b1;
    opcode = op;
    op_size = sz;
    first_operand = a;
    second_operand = b;
    step_in_bit = sb;
    stream_final = fin;
    branch_cond = br;
    @(negedge ref_clk);
    // Stale operands inverted so a late sample shows up
    op_valid = 1'b0;
    first_operand = ~a;
    second_operand = ~b;
    stream_final = 4'h0;
    branch_cond = 4'h0;
  endtask : issue
endmodule : seq_model

// *** tb_logic_stack_bitwise_unit.sv ***
`timescale 1ns/1ps
module tb_logic_stack_bitwise_unit;
  // ---------------------------------------------
  // Signals and instances
  // ---------------------------------------------
  logic ref_clk, resetn, op_valid, step_in_bit, top_r;
  logic result_valid_r, step_active_r, next_step_set_r;
  lsbu_pkg::opcode_t opcode;
  lsbu_pkg::opsize_t op_size;
  logic [31:0] first_operand, second_operand, result_r;
  logic [3:0]  stream_final, branch_cond, final_clear_r, branch_set_r;
  logic [8:0]  stack_r, m;
  int          errors, checks;

  seq_model seq (.ref_clk(ref_clk), .op_valid(op_valid),
    .opcode(opcode), .op_size(op_size), .first_operand(first_operand),
    .second_operand(second_operand), .step_in_bit(step_in_bit),
    .stream_final(stream_final), .branch_cond(branch_cond));

  logic_stack_bitwise_unit #(.DEPTH(9), .NSTEP(4)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .op_valid(op_valid),
    .opcode(opcode), .op_size(op_size), .first_operand(first_operand),
    .second_operand(second_operand), .step_in_bit(step_in_bit),
    .stream_final(stream_final), .branch_cond(branch_cond),
    .result_r(result_r), .result_valid_r(result_valid_r), .top_r(top_r),
    .stack_r(stack_r), .step_active_r(step_active_r),
    .next_step_set_r(next_step_set_r), .final_clear_r(final_clear_r),
    .branch_set_r(branch_set_r));

  // ---------------------------------------------
  // Compare tasks and closing report
  // ---------------------------------------------
  task automatic chk_stack(input logic [8:0] g, input logic [8:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %0t stack %h exp %h", $time, g, e);
    end
  endtask : chk_stack

  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %0t data %h exp %h", $time, g, e);
    end
  endtask : chk_data

  task automatic chk_step(input logic [3:0] g, input logic [3:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %0t step %h exp %h", $time, g, e);
    end
  endtask : chk_step

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // One stack command; pop and the loads refill the bottom with zero
  task automatic stk(input lsbu_pkg::opcode_t op, input logic sb);
    seq.issue(op, lsbu_pkg::size_byte, 32'h0, 32'h0, sb, 4'h0, 4'h0);
    case (op)
      lsbu_pkg::push_op: m = {m[7:0], m[0]};
      lsbu_pkg::read_op: m[0] = m[1];
      lsbu_pkg::pop_op: m = {1'b0, m[8:1]};
      lsbu_pkg::and_load_op: m = {1'b0, m[8:2], m[1] & m[0]};
      lsbu_pkg::or_load_op: m = {1'b0, m[8:2], m[1] | m[0]};
      lsbu_pkg::step_segment_begin_op: m[0] = sb;
      // Refused and step-only codes leave the stack alone
      default: m = m;
    endcase
    chk_stack(stack_r, m);
    chk_stack({8'h0, top_r}, {8'h0, m[0]});
  endtask : stk

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic test_stack;
    stk(lsbu_pkg::step_segment_begin_op, 1'b1);
    repeat (8) stk(lsbu_pkg::push_op, 1'b0);
    stk(lsbu_pkg::step_segment_begin_op, 1'b0);
    stk(lsbu_pkg::push_op, 1'b0);
    stk(lsbu_pkg::step_segment_begin_op, 1'b1);
    stk(lsbu_pkg::read_op, 1'b0);
    // Top 1 over second 0, so AND and OR give different tops
    stk(lsbu_pkg::step_segment_begin_op, 1'b1);
    stk(lsbu_pkg::and_load_op, 1'b0);
    stk(lsbu_pkg::or_load_op, 1'b0);
    stk(lsbu_pkg::pop_op, 1'b0);
    $display("test stack done");
  endtask : test_stack

  task automatic test_bitwise;
    logic [31:0] a, b, e, mk;
    a = 32'hc3a5_f00f;
    b = 32'h5a3c_ff00;
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 3; k++) begin
        e = (k == 0) ? (a & b) : (k == 1) ? (a | b) : (a ^ b);
        mk = (s == 0) ? 32'h0000_00ff :
             (s == 1) ? 32'h0000_ffff : 32'hffff_ffff;
        seq.issue(lsbu_pkg::opcode_t'(4'h6 + 4'(k)),
                  lsbu_pkg::opsize_t'(2'(s)), a, b, 1'b0, 4'h0, 4'h0);
        chk_data(result_r, e & mk);
        chk_data({31'h0, result_valid_r}, 32'h1);
      end
    end
    $display("test bitwise done");
  endtask : test_bitwise

  task automatic test_step;
    seq.issue(lsbu_pkg::step_merge_op, lsbu_pkg::size_byte, 32'h0, 32'h0,
              1'b0, 4'hb, 4'h0);
    chk_step({3'h0, next_step_set_r}, 4'h0);
    chk_step(final_clear_r, 4'h0);
    seq.issue(lsbu_pkg::step_merge_op, lsbu_pkg::size_byte, 32'h0, 32'h0,
              1'b0, 4'hf, 4'h0);
    chk_step({3'h0, next_step_set_r}, 4'h1);
    chk_step(final_clear_r, 4'hf);
    stk(lsbu_pkg::step_segment_begin_op, 1'b1);
    seq.issue(lsbu_pkg::step_branch_op, lsbu_pkg::size_byte, 32'h0, 32'h0,
              1'b0, 4'h0, 4'h6);
    chk_step(branch_set_r, 4'h2);
    stk(lsbu_pkg::step_segment_begin_op, 1'b0);
    seq.issue(lsbu_pkg::step_branch_op, lsbu_pkg::size_byte, 32'h0, 32'h0,
              1'b0, 4'h0, 4'h6);
    chk_step(branch_set_r, 4'h0);
    // Segment flag follows begin, end clears it; refused codes do nothing
    stk(lsbu_pkg::step_segment_begin_op, 1'b1);
    chk_step({3'h0, step_active_r}, 4'h1);
    stk(lsbu_pkg::step_transition_op, 1'b0);
    stk(lsbu_pkg::nop_op, 1'b0);
    stk(lsbu_pkg::step_segment_end_op, 1'b0);
    chk_step({3'h0, step_active_r}, 4'h0);
    $display("test step done");
  endtask : test_step

  // Mid-run reset clears a loaded stack, then commands resume
  task automatic test_reset;
    stk(lsbu_pkg::step_segment_begin_op, 1'b1);
    @(negedge ref_clk);
    resetn = 1'b0;
    @(negedge ref_clk);
    chk_stack(stack_r, lsbu_pkg::STACK_RST);
    chk_step({3'h0, step_active_r}, 4'h0);
    resetn = 1'b1;
    m = lsbu_pkg::STACK_RST;
    stk(lsbu_pkg::step_segment_begin_op, 1'b1);
    $display("test reset done");
  endtask : test_reset

  // ---------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    finish_test();
  end

  initial begin
    errors = 0;
    checks = 0;
    m = 9'h000;
    resetn = 1'b0;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    chk_stack(stack_r, 9'h000);
    test_stack();
    test_bitwise();
    test_step();
    test_reset();
    finish_test();
  end
endmodule : tb_logic_stack_bitwise_unit
